// ==== lnb_consts.svh ====
`ifndef LNB_CONSTS_SVH
`define LNB_CONSTS_SVH

// Clock rate in kHz (125 MHz)
`define LNB_CLK_KHZ          125000
// Tone frequency in kHz and boost-to-tone ratio
`define LNB_TONE_KHZ         22
`define LNB_BOOST_RATIO      16
// Boost clock half period in clock cycles (125000/(22*16*2), rounded down)
`define LNB_BOOST_HALF       ((`LNB_CLK_KHZ) / ((`LNB_TONE_KHZ) * (`LNB_BOOST_RATIO) * 2))
// Overcurrent disable time in ms and as clock cycles
`define LNB_OC_TIME_MS       45
`define LNB_OC_CYCLES        ((`LNB_OC_TIME_MS) * (`LNB_CLK_KHZ))
// Tone detection: edges per cycle window, detection in 1.5 cycles = 3 half cycles
`define LNB_DET_HALVES       3
// Detector period windows in clock cycles (half period bounds)
// Transmit window 20..24 kHz, receive window 17..27 kHz
`define LNB_XMT_HALF_MIN     ((`LNB_CLK_KHZ) / (24 * 2))
`define LNB_XMT_HALF_MAX     ((`LNB_CLK_KHZ) / (20 * 2))
`define LNB_RCV_HALF_MIN     ((`LNB_CLK_KHZ) / (27 * 2))
`define LNB_RCV_HALF_MAX     ((`LNB_CLK_KHZ) / (17 * 2))
// Pulse skipping thresholds in mV above target
`define LNB_SKIP_ENTER_MV    450
`define LNB_SKIP_EXIT_MV     200
// Constant low level for the open-drain data
`define LNB_ZERO1            1'b0

`endif

// ==== lnb_pkg.sv ====
package lnb_pkg;

  // Overcurrent supervisor states, gray coded along the usual path
  typedef enum logic [1:0] {
    LNB_OFF      = 2'b00,
    LNB_RUN      = 2'b01,
    LNB_LIMIT    = 2'b11,
    LNB_TRIPPED  = 2'b10
  } lnb_oc_state_type;

  // Tone detector status carrier
  typedef struct packed {
    logic present;
    logic out_data;
    logic out_oe;
  } lnb_det_type;

  // Analog front-end status from comparators
  typedef struct packed {
    logic at_limit;
    logic back_driven;
    logic boost_over_skip;
    logic boost_below_exit;
  } lnb_sense_type;

endpackage : lnb_pkg

// ==== lnb_tone_det.sv ====
`timescale 1ns/1ps
`include "lnb_consts.svh"

module lnb_tone_det #(
  parameter int CNT_W = 16    // Half period counter width
) (
  // Clock and reset
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  // Mode and input
  input  wire logic               xmt_mode_i,
  input  wire logic               tone_in_i,
  // Result
  output lnb_pkg::lnb_det_type    det_o
);
  import lnb_pkg::*;

  initial begin
    if (CNT_W < 12) $error("CNT_W too small for detector windows");
  end

  // All detector state
  typedef struct packed {
    logic [CNT_W-1:0] half_cnt;   // Cycles since last edge
    logic [1:0]       good;       // Consecutive good half periods
    logic             prev;       // Previous input level
    lnb_det_type      det;        // Registered result
  } lnb_det_state_type;

  lnb_det_state_type st;
  lnb_det_state_type next_st;
  logic [CNT_W-1:0]  lo_lim;      // Window lower bound
  logic [CNT_W-1:0]  hi_lim;      // Window upper bound

  // Window selection by mode and next-state logic
  always_comb begin
    next_st = st;
    lo_lim  = xmt_mode_i ? CNT_W'(`LNB_XMT_HALF_MIN) : CNT_W'(`LNB_RCV_HALF_MIN);
    hi_lim  = xmt_mode_i ? CNT_W'(`LNB_XMT_HALF_MAX) : CNT_W'(`LNB_RCV_HALF_MAX);
    next_st.prev = tone_in_i;
    if (tone_in_i != st.prev) begin
      // Edge: qualify the half period just ended
      next_st.half_cnt = '0;
      if (st.half_cnt >= lo_lim && st.half_cnt <= hi_lim) begin
        if (st.good != 2'(`LNB_DET_HALVES)) begin
          next_st.good = st.good + 2'd1;
        end
      end else begin
        next_st.good = '0;
      end
    end else if (st.half_cnt > hi_lim) begin
      // Tone lost: stuck input
      next_st.good = '0;
    end else begin
      next_st.half_cnt = st.half_cnt + CNT_W'(1);
    end
    // Present after three good half periods, i.e. 1.5 cycles
    next_st.det.present  = (next_st.good == 2'(`LNB_DET_HALVES));
    // Open drain: pull low while recovered tone is low
    next_st.det.out_data = `LNB_ZERO1;
    next_st.det.out_oe   = next_st.det.present & ~tone_in_i;
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign det_o = st.det;

endmodule : lnb_tone_det

// ==== lnb_fault_ctrl.sv ====
`timescale 1ns/1ps
`include "lnb_consts.svh"

// Operation
// - Boost clock is sixteen times tone
// - Limit beyond 45 ms turns output off
// - Output stays off until host re-enables
// - Short beyond 45 ms sets overcurrent flag
// - Tolerate limit current up to 45 ms
// - Back-drive never latches off
// - Tone on output only while gate high
// - Recovered tone on open-drain output
// - Tone detected flag high while present
// - Detection within 1.5 tone cycles
// - Gate selects transmit or receive window
// - Gate selects pull-down strength
// - Pulse skipping with 450/200 mV hysteresis
// - Tone gate is a synchronised pin
module lnb_fault_ctrl #(
  parameter int OC_CYCLES = `LNB_OC_CYCLES,  // Overcurrent disable time in cycles
  parameter int OC_W      = 23,              // Timer width
  parameter int DIV_W     = 8                // Boost half period counter width
) (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  // Host control pins
  input  wire logic                output_enable_i,
  input  wire logic                tone_gate_input_i,
  // Analog comparator inputs
  input  wire lnb_pkg::lnb_sense_type sense_i,
  // Tone detector input pin
  input  wire logic                tone_detect_i,
  // Power stage controls
  output logic                     boost_clk_o,
  output logic                     boost_skip_o,
  output logic                     tone_out_o,
  output logic                     output_on_o,
  output logic                     pulldown_high_o,
  output logic                     det_xmt_mode_o,
  // Status
  output logic                     overcurrent_flag_o,
  output logic                     tone_detected_flag_o,
  // Open drain tone output
  output logic                     tone_det_out_o,
  output logic                     tone_det_oe_o
);
  import lnb_pkg::*;

  initial begin
    if (OC_CYCLES < 1 || OC_CYCLES >= (1 << OC_W)) $error("OC_W cannot hold OC_CYCLES");
    if (`LNB_BOOST_HALF >= (1 << DIV_W)) $error("DIV_W too small for boost divider");
  end

  // All state of the block
  typedef struct packed {
    logic [1:0]        gate_sync;   // Tone gate synchroniser
    logic [1:0]        en_sync;     // Enable synchroniser
    logic [1:0]        det_sync;    // Tone input synchroniser
    logic [3:0]        sense_s1;    // Comparator first stage
    lnb_sense_type     sense;       // Comparator second stage
    logic              en_prev;     // Enable of last cycle, for edge
    logic [DIV_W-1:0]  div_cnt;     // Boost half period counter
    logic              boost_clk;   // Boost switching clock
    logic [3:0]        tone_div;    // Boost to tone divider
    logic              skip;        // Pulse skipping active
    lnb_oc_state_type  oc_state;    // Supervisor state
    logic [OC_W-1:0]   oc_cnt;      // Overcurrent timer
    logic              oc_flag;     // Overcurrent flag
    logic              out_on;      // Output stage on
    logic              tone_out;    // Gated tone
    logic              pd_high;     // Pull-down strength select
    logic              tone_detected_flag;        // Tone detected flag
    logic              td_oe;       // Open-drain enable
    logic              td_data;     // Open-drain data level
  } lnb_state_type;

  lnb_state_type st;
  lnb_state_type next_st;
  lnb_det_type   det;              // Detector result
  logic          gate;             // Synchronised tone gate
  logic          en;               // Synchronised enable
  logic          en_rise;          // Host re-enable event

  assign gate    = st.gate_sync[1];
  assign en      = st.en_sync[1];
  assign en_rise = en & ~st.en_prev;

  // Tone detector on synchronised input, mode from tone gate
  lnb_tone_det #(
    .CNT_W (16)
  ) u_det (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .xmt_mode_i (gate),
    .tone_in_i  (st.det_sync[1]),
    .det_o      (det)
  );

  // Next-state logic
  always_comb begin
    next_st = st;
    // Pin synchronisers, two flops each
    next_st.gate_sync = {st.gate_sync[0], tone_gate_input_i};
    next_st.en_sync   = {st.en_sync[0], output_enable_i};
    next_st.det_sync  = {st.det_sync[0], tone_detect_i};
    next_st.sense_s1  = sense_i;
    next_st.sense     = st.sense_s1;
    next_st.en_prev   = en;

    // Common divider: boost clock, then tone at one sixteenth
    if (st.div_cnt == DIV_W'(`LNB_BOOST_HALF - 1)) begin
      next_st.div_cnt   = '0;
      next_st.boost_clk = ~st.boost_clk;
      if (st.boost_clk) begin
        // Full boost period: advance tone divider
        next_st.tone_div = st.tone_div + 4'd1;
      end
    end else begin
      next_st.div_cnt = st.div_cnt + DIV_W'(1);
    end

    // Pulse skipping hysteresis from comparators
    if (st.sense.boost_over_skip) begin
      next_st.skip = 1'b1;
    end else if (st.sense.boost_below_exit) begin
      next_st.skip = 1'b0;
    end

    // Overcurrent supervisor
    case (st.oc_state)
      LNB_OFF: begin
        next_st.oc_cnt = '0;
        next_st.out_on = 1'b0;
        if (en) begin
          next_st.oc_state = LNB_RUN;
          next_st.out_on   = 1'b1;
        end
      end
      LNB_RUN: begin
        next_st.oc_cnt = '0;
        if (!en) begin
          next_st.oc_state = LNB_OFF;
          next_st.out_on   = 1'b0;
        end else if (st.sense.at_limit && !st.sense.back_driven) begin
          // Back-drive is not a current limit and never starts the timer
          next_st.oc_state = LNB_LIMIT;
          next_st.oc_cnt   = OC_W'(1);
        end
      end
      LNB_LIMIT: begin
        if (!en) begin
          next_st.oc_state = LNB_OFF;
          next_st.out_on   = 1'b0;
        end else if (!st.sense.at_limit || st.sense.back_driven) begin
          // Current fell below limit or output back-driven: restart timer
          next_st.oc_state = LNB_RUN;
          next_st.oc_cnt   = '0;
        end else if (st.oc_cnt >= OC_W'(OC_CYCLES)) begin
          // Limit held beyond the disable time
          next_st.oc_state = LNB_TRIPPED;
          next_st.out_on   = 1'b0;
          next_st.oc_flag  = 1'b1;
        end else begin
          // Start-up in-rush tolerated while counting
          next_st.oc_cnt = st.oc_cnt + OC_W'(1);
        end
      end
      LNB_TRIPPED: begin
        // Latched off until host re-enables
        next_st.out_on = 1'b0;
        if (en_rise) begin
          next_st.oc_state = LNB_RUN;
          next_st.out_on   = 1'b1;
          next_st.oc_flag  = 1'b0;
          next_st.oc_cnt   = '0;
        end
      end
      default: begin
        next_st.oc_state = LNB_OFF;
      end
    endcase

    // Tone gating and pull-down strength
    next_st.tone_out = gate & st.tone_div[3] & next_st.out_on;
    next_st.pd_high  = gate;

    // Detector status
    next_st.tone_detected_flag  = det.present;
    next_st.td_oe   = det.out_oe;
    next_st.td_data = det.out_data;
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign boost_clk_o          = st.boost_clk;
  assign boost_skip_o         = st.skip;
  assign tone_out_o           = st.tone_out;
  assign output_on_o          = st.out_on;
  assign pulldown_high_o      = st.pd_high;
  assign det_xmt_mode_o       = st.gate_sync[1];
  assign overcurrent_flag_o   = st.oc_flag;
  assign tone_detected_flag_o = st.tone_detected_flag;
  assign tone_det_out_o       = st.td_data;
  assign tone_det_oe_o        = st.td_oe;

endmodule : lnb_fault_ctrl

// ==== lnb_fault_sva.sv ====
`timescale 1ns/1ps
module lnb_fault_sva #(
  parameter int OC_CYCLES = 50  // Disable time in cycles
) (
  // Clock and reset
  input wire logic                   clock_i,
  input wire logic                   rst_i,
  // Watched inputs
  input wire logic                   output_enable_i,
  input wire logic                   tone_gate_input_i,
  input wire lnb_pkg::lnb_sense_type sense_i,
  // Watched outputs
  input wire logic                   boost_clk_o,
  input wire logic                   boost_skip_o,
  input wire logic                   tone_out_o,
  input wire logic                   output_on_o,
  input wire logic                   pulldown_high_o,
  input wire logic                   det_xmt_mode_o,
  input wire logic                   overcurrent_flag_o,
  input wire logic                   tone_detected_flag_o,
  input wire logic                   tone_det_out_o,
  input wire logic                   tone_det_oe_o
);
  import lnb_pkg::*;
  localparam int HALF = 177;  // Boost half period in cycles
  int   lim_cnt;  // Cycles of uncancelled limit current
  int   bc_cnt;   // Cycles since last boost edge
  logic bc_seen;  // First boost edge seen
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Helper counters; back-drive cancels the limit count
  always_ff @(posedge clock_i) begin
    if (rst_i || !sense_i.at_limit || sense_i.back_driven) lim_cnt <= 0;
    else lim_cnt <= lim_cnt + 1;
    if (rst_i) begin
      bc_cnt <= 0;
      bc_seen <= 1'b0;
    end else if ($changed(boost_clk_o)) begin
      bc_cnt <= 0;
      bc_seen <= 1'b1;
    end else begin
      bc_cnt <= bc_cnt + 1;
    end
  end
  // Gate held steadily past the synchronisers
  sequence s_gate_lo; !tone_gate_input_i [*4]; endsequence
  sequence s_gate_hi; tone_gate_input_i [*4]; endsequence
  a_trip_after_time: assert property ($rose(overcurrent_flag_o) |-> $past(lim_cnt, 2) > OC_CYCLES)
    else $error("trip before disable time");
  a_trip_output_off: assert property (overcurrent_flag_o |-> !output_on_o)
    else $error("output on while tripped");
  a_flag_held: assert property (overcurrent_flag_o && !output_enable_i |=> overcurrent_flag_o)
    else $error("flag cleared without re-enable");
  a_backdrive_no_trip: assert property ($rose(overcurrent_flag_o) |-> !$past(sense_i.back_driven, 3))
    else $error("trip while back-driven");
  a_tone_gated: assert property (s_gate_lo |-> !tone_out_o)
    else $error("tone while gate low");
  a_pulldown_sel: assert property ((s_gate_hi |-> pulldown_high_o) and (s_gate_lo |-> !pulldown_high_o))
    else $error("pull-down not following gate");
  a_det_mode_sel: assert property ((s_gate_hi |-> det_xmt_mode_o) and (s_gate_lo |-> !det_xmt_mode_o))
    else $error("detector mode not following gate");
  a_boost_half: assert property ($changed(boost_clk_o) && bc_seen |-> bc_cnt == HALF - 1)
    else $error("boost half period wrong");
  a_od_data_low: assert property (!tone_det_out_o)
    else $error("open-drain data driven high");
  a_oe_needs_tone: assert property (tone_det_oe_o |-> tone_detected_flag_o)
    else $error("line pulled without tone");
  a_skip_enter: assert property ((sense_i.boost_over_skip && !sense_i.boost_below_exit) [*4] |-> boost_skip_o)
    else $error("pulse skipping not entered");
endmodule : lnb_fault_sva

bind lnb_fault_ctrl lnb_fault_sva #(.OC_CYCLES(OC_CYCLES)) u_sva (
  .clock_i, .rst_i, .output_enable_i, .tone_gate_input_i, .sense_i, .boost_clk_o,
  .boost_skip_o, .tone_out_o, .output_on_o, .pulldown_high_o, .det_xmt_mode_o,
  .overcurrent_flag_o, .tone_detected_flag_o, .tone_det_out_o, .tone_det_oe_o
);

// ==== lnb_tone_src.sv ====
`timescale 1ns/1ps
module lnb_tone_src (
  // Clock and control
  input  wire logic        clock_i,
  input  wire logic        run_i,
  input  wire logic [15:0] half_i,
  // Squared tone towards the detector pin
  output logic             tone_o
);
  int cnt;  // Cycles into the current half period
  // Square wave while running; the coupled input rests low otherwise
  always_ff @(posedge clock_i) begin
    if (!run_i) begin
      cnt <= 0;
      tone_o <= 1'b0;
    end else if (cnt >= half_i - 1) begin
      cnt <= 0;
      tone_o <= !tone_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : lnb_tone_src

// ==== lnb_fault_timer_tone_control_tb_top.sv ====
`timescale 1ns/1ps
`include "lnb_consts.svh"
module lnb_fault_timer_tone_control_tb_top;
  import lnb_pkg::*;
  localparam int OC = 50;                    // Shortened disable time
  localparam int BP = 2 * `LNB_BOOST_HALF;   // Boost period in cycles
  localparam logic [15:0] TH = 16'h0b19;     // Half period near 22 kHz
  localparam logic [15:0] WH = 16'h0992;     // Half period in receive window only
  logic          clock_i = 1'b0;             // Clock
  logic          rst_i = 1'b1;               // Reset
  logic          enable = 1'b0;              // Host enable pin
  logic          gate = 1'b0;                // Tone gate pin
  lnb_sense_type sense = '0;                 // Comparator levels
  logic          run = 1'b0;                 // Far tone on
  logic [15:0]   half = TH;                  // Far tone half period
  logic          tone_line;                  // Detector input
  logic          bclk, skip, tone, on, pdh, xmt, ocf, tdf, tdo, tdoe;
  int            fail_count = 0;
  int            num_checks = 0;
  int            cycles = 0;
  int            n;
  always #4 clock_i = ~clock_i;
  lnb_fault_ctrl #(.OC_CYCLES(OC)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .output_enable_i(enable), .tone_gate_input_i(gate),
    .sense_i(sense), .tone_detect_i(tone_line), .boost_clk_o(bclk), .boost_skip_o(skip),
    .tone_out_o(tone), .output_on_o(on), .pulldown_high_o(pdh), .det_xmt_mode_o(xmt),
    .overcurrent_flag_o(ocf), .tone_detected_flag_o(tdf), .tone_det_out_o(tdo),
    .tone_det_oe_o(tdoe));
  lnb_tone_src src (.clock_i(clock_i), .run_i(run), .half_i(half), .tone_o(tone_line));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Let edges pass, then sample settled outputs
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : cyc
  // Cycles between two rising edges of tone (sel 0) or boost clock (sel 1), zero if none
  task automatic per(input bit sel, output int p);
    int   e;
    logic q;
    logic s;
    e = 0;
    p = 0;
    q = sel ? bclk : tone;
    for (int k = 0; k < 12000 && e < 2; k++) begin
      cyc(1);
      s = sel ? bclk : tone;
      if (e == 1) p++;
      if (s === 1'b1 && q === 1'b0) e++;
      q = s;
    end
  endtask : per
  // Limit timing, trip, refusal and re-enable
  task automatic t_overcurrent;
    @(posedge clock_i) enable <= 1'b1;
    cyc(6);
    chk({on, ocf}, 2'h2);
    for (int i = 0; i < 2; i++) begin
      @(posedge clock_i) sense.at_limit <= 1'b1;
      cyc(OC - 5);
      @(posedge clock_i) sense.at_limit <= 1'b0;
      cyc(4);
      chk({on, ocf}, 2'h2);
    end
    @(posedge clock_i) sense.at_limit <= 1'b1;
    cyc(OC + 8);
    chk({on, ocf}, 2'h1);
    @(posedge clock_i) sense.at_limit <= 1'b0;
    cyc(100);  // No automatic restart without host re-enable
    chk({on, ocf}, 2'h1);
    @(posedge clock_i) enable <= 1'b0;
    cyc(4);
    @(posedge clock_i) enable <= 1'b1;
    cyc(6);
    chk({on, ocf}, 2'h2);
  endtask : t_overcurrent
  // Back-driven output at the limit never trips
  task automatic t_backdrive;
    @(posedge clock_i) sense <= 4'hc;
    cyc(OC + 20);
    chk({on, ocf}, 2'h2);
    @(posedge clock_i) sense <= 4'h0;
    cyc(4);
  endtask : t_backdrive
  // Pulse skipping with hysteresis
  task automatic t_skip;
    @(posedge clock_i) sense <= 4'h2;
    cyc(5);
    chk(skip, 1'b1);
    @(posedge clock_i) sense <= 4'h0;
    cyc(5);
    chk(skip, 1'b1);
    @(posedge clock_i) sense <= 4'h1;
    cyc(5);
    chk(skip, 1'b0);
    @(posedge clock_i) sense <= 4'h0;
  endtask : t_skip
  // Tone gating, pull-down, mode and divider ratio
  task automatic t_tone;
    cyc(5);
    chk({pdh, xmt}, 2'h0);
    per(1'b0, n);
    chk(n, 0);
    @(posedge clock_i) gate <= 1'b1;
    cyc(5);
    chk({pdh, xmt}, 2'h3);
    per(1'b0, n);
    chk(n, 16 * BP);
    per(1'b1, n);
    chk(n, BP);
  endtask : t_tone
  // Detection delay, loss of tone and mode windows
  task automatic t_detect;
    @(posedge clock_i) run <= 1'b1;
    cyc(4 * TH + 20);
    chk(tdf, 1'b1);
    @(posedge clock_i) run <= 1'b0;
    cyc(4000);
    chk(tdf, 1'b0);
    @(posedge clock_i) half <= WH;
    @(posedge clock_i) run <= 1'b1;
    cyc(5 * WH);
    chk(tdf, 1'b0);
    @(posedge clock_i) gate <= 1'b0;
    cyc(5 * WH);
    chk(tdf, 1'b1);
    // Line pulled low for exactly the low half of each recovered period
    n = 0;
    for (int k = 0; k < 2 * WH; k++) begin
      cyc(1);
      if (tdoe === 1'b1) n++;
    end
    chk(n, WH);
    chk(tdo, 1'b0);
    @(posedge clock_i) run <= 1'b0;
  endtask : t_detect
  // Final report and end of run
  task automatic give_verdict;
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    cyc(2);
    t_overcurrent();
    t_backdrive();
    t_skip();
    t_tone();
    t_detect();
    give_verdict();
  end
endmodule : lnb_fault_timer_tone_control_tb_top
